// ==== logic/pdmc_pkg.sv ====
// Package of constants and types for the power-down mode controller.
package pdmc_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	// The control register is register index FFFFFF82; its word sits at four times the index.
	localparam logic [31:0] STANDBY_CONTROL_INDEX = 32'hFFFFFF82;
	localparam logic [7:0] STANDBY_CONTROL_RESET = 8'h00;
	localparam logic [7:0] STANDBY_CONTROL_MASK = 8'h87;
	localparam int DEEP_HALT_SELECT_BIT = 7;
	localparam int TIMER_UNIT_CLOCK_STOP_BIT = 2;
	localparam int RTC_CLOCK_STOP_BIT = 1;
	localparam int SERIAL_PORT_CLOCK_STOP_BIT = 0;
	localparam int STANDBY_CONTROL_LANE = 0;

	// ----------------------------------------
	// Operating states
	// ----------------------------------------
	typedef enum logic [1:0] {
		PDMC_RUN = 2'b00,
		PDMC_SLEEP = 2'b01,
		PDMC_STANDBY = 2'b10,
		PDMC_HW_STANDBY = 2'b11
	} pdmc_state_t;

	// Status pin codes, high bit first.
	localparam logic [1:0] STATE_CODE_RESET = 2'b11;
	localparam logic [1:0] STATE_CODE_SLEEP = 2'b10;
	localparam logic [1:0] STATE_CODE_STANDBY = 2'b01;
	localparam logic [1:0] STATE_CODE_NORMAL = 2'b00;

	// Clock enables, self-refresh and pin controls handed to the rest of the chip.
	typedef struct packed {
		logic cpu;
		logic clock_generator;
		logic timer_unit;
		logic rtc_bus;
		logic rtc_count;
		logic serial_port;
		logic self_refresh;
		logic serial_port_pin_reset;
		logic timer_unit_pin_hold;
	} pdmc_gates_t;

endpackage

// ==== logic/pdmc_top.sv ====
// Power-down mode controller with its APB standby control register.
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
module pdmc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic halt_exec,
	input wire logic wake_irq,
	input wire logic hw_standby_request_n,
	input wire logic rtc_run,
	input wire logic timer_unit_on_rtc,
	output logic state_code_high,
	output logic state_code_low,
	output pdmc_pkg::pdmc_gates_t gates
);

	// ----------------------------------------
	// Register access
	// ----------------------------------------
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic hit;
	logic access;

	// The word address is the index times four, so only the low thirty index bits fit the bus.
	assign hit = (paddr[31:2] == pdmc_pkg::STANDBY_CONTROL_INDEX[29:0]);
	assign access = psel && penable;
	assign pready = 1'b1;
	assign pslverr = access && !hit;
	assign prdata = prdata_r;

	always_comb begin
		ctrl_nxt = ctrl_r;
		prdata_nxt = prdata_r;
		if (access && hit && pwrite && pstrb[pdmc_pkg::STANDBY_CONTROL_LANE]) begin
			ctrl_nxt = pwdata[7:0] & pdmc_pkg::STANDBY_CONTROL_MASK;
		end
		if (psel && !penable && !pwrite) begin
			prdata_nxt = hit ? {24'h000000, ctrl_r} : 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= pdmc_pkg::STANDBY_CONTROL_RESET;
			prdata_r <= 32'h00000000;
		end else if (clk_en) begin
			ctrl_r <= ctrl_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// ----------------------------------------
	// Mode sequencing
	// ----------------------------------------
	pdmc_pkg::pdmc_state_t state_r;
	pdmc_pkg::pdmc_state_t state_nxt;
	logic in_reset_r;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			pdmc_pkg::PDMC_RUN: begin
				if (halt_exec) begin
					state_nxt = ctrl_r[pdmc_pkg::DEEP_HALT_SELECT_BIT] ?
						pdmc_pkg::PDMC_STANDBY : pdmc_pkg::PDMC_SLEEP;
				end
			end
			pdmc_pkg::PDMC_SLEEP: begin
				if (wake_irq) begin
					state_nxt = pdmc_pkg::PDMC_RUN;
				end
			end
			pdmc_pkg::PDMC_STANDBY: begin
				if (wake_irq) begin
					state_nxt = pdmc_pkg::PDMC_RUN;
				end
			end
			pdmc_pkg::PDMC_HW_STANDBY: begin
				state_nxt = pdmc_pkg::PDMC_HW_STANDBY;
			end
			default: begin
				state_nxt = pdmc_pkg::PDMC_RUN;
			end
		endcase
		if (!hw_standby_request_n) begin
			state_nxt = pdmc_pkg::PDMC_HW_STANDBY;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= pdmc_pkg::PDMC_RUN;
			in_reset_r <= 1'b1;
		end else if (clk_en) begin
			state_r <= state_nxt;
			in_reset_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Clock gating and status pins
	// ----------------------------------------
	logic deep;
	logic [1:0] code;

	// Hardware standby shows the standby code, as deep covers both; it also stops a timer unit fed by the real-time clock.
	assign deep = (state_r == pdmc_pkg::PDMC_STANDBY) || (state_r == pdmc_pkg::PDMC_HW_STANDBY);

	always_comb begin
		gates.cpu = (state_r == pdmc_pkg::PDMC_RUN);
		gates.clock_generator = !deep;
		gates.timer_unit = !ctrl_r[pdmc_pkg::TIMER_UNIT_CLOCK_STOP_BIT] &&
			(!deep || (state_r == pdmc_pkg::PDMC_STANDBY && timer_unit_on_rtc));
		gates.rtc_bus = !ctrl_r[pdmc_pkg::RTC_CLOCK_STOP_BIT] && !deep;
		gates.rtc_count = !deep || rtc_run;
		gates.serial_port = !ctrl_r[pdmc_pkg::SERIAL_PORT_CLOCK_STOP_BIT] && !deep;
		gates.self_refresh = deep;
		gates.serial_port_pin_reset = ctrl_r[pdmc_pkg::SERIAL_PORT_CLOCK_STOP_BIT];
		gates.timer_unit_pin_hold = ctrl_r[pdmc_pkg::TIMER_UNIT_CLOCK_STOP_BIT];
		if (in_reset_r) begin
			code = pdmc_pkg::STATE_CODE_RESET;
		end else if (state_r == pdmc_pkg::PDMC_SLEEP) begin
			code = pdmc_pkg::STATE_CODE_SLEEP;
		end else if (deep) begin
			code = pdmc_pkg::STATE_CODE_STANDBY;
		end else begin
			code = pdmc_pkg::STATE_CODE_NORMAL;
		end
	end

	assign state_code_high = code[1];
	assign state_code_low = code[0];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_halt_select: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && state_r == pdmc_pkg::PDMC_RUN && halt_exec && hw_standby_request_n)
		|=> (state_r == ($past(ctrl_r[7]) ? pdmc_pkg::PDMC_STANDBY : pdmc_pkg::PDMC_SLEEP)))
		else $error("halt entered the wrong mode");
	chk_sleep_wake: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && state_r == pdmc_pkg::PDMC_SLEEP && wake_irq && hw_standby_request_n)
		|=> state_r == pdmc_pkg::PDMC_RUN) else $error("sleep not left on interrupt");
	chk_standby_gates: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == pdmc_pkg::PDMC_STANDBY |-> !gates.cpu && !gates.serial_port && gates.self_refresh)
		else $error("standby gates wrong");
	chk_hw_stays: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == pdmc_pkg::PDMC_HW_STANDBY |=> state_r == pdmc_pkg::PDMC_HW_STANDBY)
		else $error("hardware standby left without reset");
	chk_rtc_count: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == pdmc_pkg::PDMC_STANDBY && rtc_run) |-> gates.rtc_count)
		else $error("rtc counter stopped in standby");
	chk_reg_write: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && access && hit && pwrite && pstrb[0])
		|=> ctrl_r == ($past(pwdata[7:0]) & pdmc_pkg::STANDBY_CONTROL_MASK))
		else $error("control write stored wrongly");
	chk_sp_stop: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_r[0] |-> !gates.serial_port && gates.serial_port_pin_reset)
		else $error("serial port clock not stopped");
	chk_status_sleep: assert property (@(posedge pclk) disable iff (!presetn)
		(!in_reset_r && state_r == pdmc_pkg::PDMC_SLEEP) |-> state_code_high && !state_code_low)
		else $error("sleep status code wrong");

	// ----------------------------------------
	// Mode entry and exit checks
	// ----------------------------------------
	// Each halt must land in one low-power mode, never stay in run.
	chk_halt_leaves: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && state_r == pdmc_pkg::PDMC_RUN && halt_exec && hw_standby_request_n)
		|=> (state_r == pdmc_pkg::PDMC_SLEEP || state_r == pdmc_pkg::PDMC_STANDBY))
		else $error("halt did not enter a low power mode");

	chk_standby_wake: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && state_r == pdmc_pkg::PDMC_STANDBY && wake_irq && hw_standby_request_n)
		|=> state_r == pdmc_pkg::PDMC_RUN)
		else $error("standby not left on interrupt");

	// The pin wins over any halt or wake that arrives in the same cycle.
	chk_hw_entry: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && !hw_standby_request_n)
		|=> state_r == pdmc_pkg::PDMC_HW_STANDBY)
		else $error("hardware standby not entered");

	// ----------------------------------------
	// Clock gate checks
	// ----------------------------------------
	chk_sleep_gates: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == pdmc_pkg::PDMC_SLEEP
		|-> !gates.cpu && gates.clock_generator && !gates.self_refresh)
		else $error("sleep gates wrong");

	chk_hw_gates: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == pdmc_pkg::PDMC_HW_STANDBY
		|-> !gates.cpu && !gates.clock_generator && !gates.timer_unit && gates.self_refresh)
		else $error("hardware standby gates wrong");

	chk_run_core: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == pdmc_pkg::PDMC_RUN
		|-> gates.cpu && gates.clock_generator && !gates.self_refresh)
		else $error("core clock stopped in run");

	chk_tu_stop: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_r[pdmc_pkg::TIMER_UNIT_CLOCK_STOP_BIT]
		|-> !gates.timer_unit && gates.timer_unit_pin_hold)
		else $error("timer unit clock not stopped");

	chk_tu_run: assert property (@(posedge pclk) disable iff (!presetn)
		(!ctrl_r[pdmc_pkg::TIMER_UNIT_CLOCK_STOP_BIT] && state_r == pdmc_pkg::PDMC_RUN)
		|-> gates.timer_unit && !gates.timer_unit_pin_hold)
		else $error("timer unit clock stopped in run");

	// A timer clocked from the real-time clock must survive software standby.
	chk_tu_standby: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == pdmc_pkg::PDMC_STANDBY && timer_unit_on_rtc &&
		!ctrl_r[pdmc_pkg::TIMER_UNIT_CLOCK_STOP_BIT]) |-> gates.timer_unit)
		else $error("timer unit stopped although fed by rtc");

	// Only the bus side of the real-time clock stops; its counter must go on.
	chk_rtc_bus_stop: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl_r[pdmc_pkg::RTC_CLOCK_STOP_BIT] && state_r == pdmc_pkg::PDMC_RUN)
		|-> !gates.rtc_bus && gates.rtc_count)
		else $error("rtc bus clock not stopped");

	chk_rtc_bus_run: assert property (@(posedge pclk) disable iff (!presetn)
		(!ctrl_r[pdmc_pkg::RTC_CLOCK_STOP_BIT] && state_r == pdmc_pkg::PDMC_RUN)
		|-> gates.rtc_bus)
		else $error("rtc bus clock stopped in run");

	chk_sp_run: assert property (@(posedge pclk) disable iff (!presetn)
		(!ctrl_r[pdmc_pkg::SERIAL_PORT_CLOCK_STOP_BIT] && state_r == pdmc_pkg::PDMC_RUN)
		|-> gates.serial_port && !gates.serial_port_pin_reset)
		else $error("serial port clock stopped in run");

	// ----------------------------------------
	// Status pin checks
	// ----------------------------------------
	chk_status_reset: assert property (@(posedge pclk) disable iff (!presetn)
		in_reset_r |-> state_code_high && state_code_low)
		else $error("reset status code wrong");

	chk_status_standby: assert property (@(posedge pclk) disable iff (!presetn)
		(!in_reset_r && deep) |-> !state_code_high && state_code_low)
		else $error("standby status code wrong");

	chk_status_normal: assert property (@(posedge pclk) disable iff (!presetn)
		(!in_reset_r && state_r == pdmc_pkg::PDMC_RUN) |-> !state_code_high && !state_code_low)
		else $error("normal status code wrong");

	// ----------------------------------------
	// Register checks
	// ----------------------------------------
	// Until the first enabled edge the register can only hold its reset value.
	chk_reset_zero: assert property (@(posedge pclk) disable iff (!presetn)
		in_reset_r |-> ctrl_r == pdmc_pkg::STANDBY_CONTROL_RESET)
		else $error("control register not cleared by reset");

	chk_read_data: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && psel && !penable && !pwrite && hit)
		|=> prdata == {24'h000000, $past(ctrl_r)})
		else $error("read data wrong");

	chk_refused_write: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && access && !hit) |=> $stable(ctrl_r))
		else $error("unmapped write changed the register");

	chk_frozen: assert property (@(posedge pclk) disable iff (!presetn)
		!clk_en |=> $stable(ctrl_r) && $stable(state_r))
		else $error("state moved while clock enable low");

	cov_sleep: cover property (@(posedge pclk) state_r == pdmc_pkg::PDMC_SLEEP);
	cov_standby: cover property (@(posedge pclk) state_r == pdmc_pkg::PDMC_STANDBY);
	cov_hw: cover property (@(posedge pclk) state_r == pdmc_pkg::PDMC_HW_STANDBY);
	cov_all_stop: cover property (@(posedge pclk) ctrl_r[2:0] == 3'b111);

endmodule

// ==== sim/pdmc_cpu_model.sv ====
// Behavioural CPU core that issues the halt instruction.
`timescale 1ns/100ps
module pdmc_cpu_model (
	input wire logic halt_go,
	input wire logic cpu_on,
	output logic halt_exec
);
	// A halted core executes nothing, so a request dies while its clock is off.
	assign halt_exec = halt_go & cpu_on;
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the power-down mode controller.
`timescale 1ns/100ps
module testbench;
	localparam logic [31:0] CTRL = {pdmc_pkg::STANDBY_CONTROL_INDEX[29:0], 2'b00};
	logic pclk = 1'h0, presetn = 1'h0, clk_en = 1'h1, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, pready, pslverr, err, halt_go = 1'h0, halt_exec, wake_irq = 1'h0;
	logic hw_n = 1'h1, rtc_run = 1'h0, tu_rtc = 1'h0, sc_high, sc_low;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'h0;
	logic [7:0] v;
	pdmc_pkg::pdmc_gates_t gates;
	int miscompares = 0, total_checks = 0, m_ctrl = 0, i;
	always #5 pclk = ~pclk;
	pdmc_top pdmc_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_exec(halt_exec),
		.wake_irq(wake_irq), .hw_standby_request_n(hw_n), .rtc_run(rtc_run),
		.timer_unit_on_rtc(tu_rtc), .state_code_high(sc_high), .state_code_low(sc_low),
		.gates(gates));
	pdmc_cpu_model pdmc_cpu_model_inst (.halt_go(halt_go), .cpu_on(gates.cpu),
		.halt_exec(halt_exec));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (miscompares == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'h1;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50) miscompares++;
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Pulses halt and wake requests for one cycle, then lets the result settle.
	task automatic kick(input logic h, input logic w);
		@(posedge pclk);
		halt_go <= h;
		wake_irq <= w;
		@(posedge pclk);
		halt_go <= 1'h0;
		wake_irq <= 1'h0;
		#1;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(32'h4DFC));
		repeat (8) @(posedge pclk);
		#1 chk({sc_high, sc_low}, 2'h3);
		apb(1'h0, CTRL, 32'h0);
		presetn <= 1'h1;
		apb(1'h0, CTRL, 32'h0);
		chk(rd, 32'h0);
		for (i = 0; i < 8; i++) begin
			v = ($urandom & 8'hF8) | i[7:0];
			apb(1'h1, CTRL, {24'h0, v});
			m_ctrl = v & 8'h87;
			apb(1'h0, CTRL, 32'h0);
			chk(rd, m_ctrl);
			chk({gates.cpu, gates.clock_generator, gates.timer_unit, gates.rtc_bus,
				gates.serial_port, gates.timer_unit_pin_hold, gates.serial_port_pin_reset},
				{2'h3, ~v[2], ~v[1], ~v[0], v[2], v[0]});
		end
		apb(1'h1, CTRL + 32'h4, 32'hFFFFFFFF);
		chk(err, 1'h1);
		apb(1'h0, CTRL, 32'h0);
		chk(rd, m_ctrl);
		apb(1'h1, CTRL, 32'h0);
		kick(1'h1, 1'h0);
		chk({sc_high, sc_low, gates.cpu, gates.clock_generator}, 4'h9);
		kick(1'h0, 1'h1);
		chk({sc_high, sc_low}, 2'h0);
		apb(1'h1, CTRL, 32'h00000080);
		rtc_run <= 1'($urandom);
		kick(1'h1, 1'h0);
		chk({sc_high, sc_low, gates.cpu, gates.clock_generator, gates.self_refresh,
			gates.rtc_count}, {4'h4, 1'h1, rtc_run});
		kick(1'h0, 1'h1);
		chk({sc_high, sc_low}, 2'h0);
		hw_n <= 1'h0;
		kick(1'h0, 1'h1);
		chk({sc_high, sc_low, gates.cpu, gates.timer_unit, gates.self_refresh}, 5'h9);
		presetn <= 1'h0;
		#1 chk({sc_high, sc_low}, 2'h3);
		hw_n <= 1'h1;
		apb(1'h0, CTRL, 32'h0);
		presetn <= 1'h1;
		apb(1'h0, CTRL, 32'h0);
		chk({sc_high, sc_low}, 2'h0);
		chk(rd, 32'h0);
		close_out();
	end
	initial begin
		#100000;
		miscompares++;
		close_out();
	end
endmodule
